// [rtl/tap_defs.vh]
`ifndef TAP_DEFS_VH
`define TAP_DEFS_VH
// Instruction register width and codes
`define IR_WIDTH 10
`define IR_BYPASS 10'h3FF
`define IR_IDCODE 10'h006
`define IR_EXTEST 10'h00F
`define IR_SAMPLE 10'h005
`define IR_HIGHZ 10'h00B
`define IR_CLAMP 10'h00A
`define IR_USERCODE 10'h007
// Identification register, arbitrary neutral value (LSB must be 1)
`define ID_VALUE 32'h0000_0F01
// Number of user I/O pins carrying a boundary cell
`define IO_COUNT 4
// Bits per boundary cell and positions within a cell
`define CELL_BITS 3
`define CELL_IN 0
`define CELL_OE 1
`define CELL_OUT 2
// Consecutive TMS-high clocks that force reset
`define RESET_TMS_COUNT 5
`endif

// [rtl/jtag_boundary_scan_tap.v]
// What this block does
// - Four pins only, no test reset pin
// - Sample serial input on rising test clock
// - Serial output changes on falling edge
// - Serial output enabled only while shifting
// - Mode select sampled on rising edge
// - Instruction selects action and data register
// - One-bit bypass register as shortest path
// - Boundary chain of three-bit cells per pin
// - Chain shifts from serial in toward out
// - Cells capture core value, enable, pad input
// - Update stages drive pad value, enable, core
// - Controller makes global shift, capture, update
// - Decoder makes cell mode select signal
// - No cells for supply or ground pins
// - Works regardless of configuration state
// - Patterns shifted in, captured values out
// - Force pins, capture pins or core anytime
// - All-ones code selects bypass register
// - Identification code selects ID register
// - External test drives and captures pins
// - Sample/preload snapshots pins, preloads pattern
`include "tap_defs.vh"
`default_nettype none

module jtag_boundary_scan_tap (
    input wire ref_clk_in,
    input wire rstn_in,
    input wire tck_in,
    input wire tms_in,
    input wire tdi_in,
    output reg tdo_out,
    output reg tdo_oe_out,
    input wire [`IO_COUNT-1:0] core_output_value_in,
    input wire [`IO_COUNT-1:0] core_output_enable_in,
    input wire [`IO_COUNT-1:0] pad_in,
    output reg [`IO_COUNT-1:0] pad_out,
    output reg [`IO_COUNT-1:0] pad_oe_out,
    output reg [`IO_COUNT-1:0] core_input_drive_out
);

    // ==================================================
    // Controller state codes
    localparam [3:0] ST_RESET = 4'h0;
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_SEL_DR = 4'h2;
    localparam [3:0] ST_CAP_DR = 4'h3;
    localparam [3:0] ST_SH_DR = 4'h4;
    localparam [3:0] ST_EX1_DR = 4'h5;
    localparam [3:0] ST_PAU_DR = 4'h6;
    localparam [3:0] ST_EX2_DR = 4'h7;
    localparam [3:0] ST_UPD_DR = 4'h8;
    localparam [3:0] ST_SEL_IR = 4'h9;
    localparam [3:0] ST_CAP_IR = 4'hA;
    localparam [3:0] ST_SH_IR = 4'hB;
    localparam [3:0] ST_EX1_IR = 4'hC;
    localparam [3:0] ST_PAU_IR = 4'hD;
    localparam [3:0] ST_EX2_IR = 4'hE;
    localparam [3:0] ST_UPD_IR = 4'hF;
    // Chain holds cells for user pins only; supply pins get none
    localparam CHAIN_LEN = `IO_COUNT * `CELL_BITS;

    // ==================================================
    // Reset release through two flops
    reg [1:0] rst_sync_ff;
    wire rst_n;
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // ==================================================
    // Pin synchronisers: three stages, change taken when last two agree
    reg [2:0] tck_sync_ff;
    reg [2:0] tms_sync_ff;
    reg [2:0] tdi_sync_ff;
    reg tck_lvl_ff;
    reg tms_lvl_ff;
    reg tdi_lvl_ff;

    // Level follows the pin once the last two stages agree, so a single
    // metastable sample can never make a false test clock edge
    function settle;
        input [2:0] sync;
        input lvl;
        begin
            if (sync[2] == sync[1]) begin
                settle = sync[2];
            end else begin
                settle = lvl;
            end
        end
    endfunction

    // Data stages reset high like the pin pull-ups; no false mode bits
    always @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            tck_sync_ff <= 3'h0;
            tms_sync_ff <= 3'h7;
            tdi_sync_ff <= 3'h7;
            tck_lvl_ff <= 1'b0;
            tms_lvl_ff <= 1'b1;
            tdi_lvl_ff <= 1'b1;
        end else begin
            tck_sync_ff <= {tck_sync_ff[1:0], tck_in};
            tms_sync_ff <= {tms_sync_ff[1:0], tms_in};
            tdi_sync_ff <= {tdi_sync_ff[1:0], tdi_in};
            tck_lvl_ff <= settle(tck_sync_ff, tck_lvl_ff);
            tms_lvl_ff <= settle(tms_sync_ff, tms_lvl_ff);
            tdi_lvl_ff <= settle(tdi_sync_ff, tdi_lvl_ff);
        end
    end

    // Edge strobes of the test clock; the level stage lags data by one
    // cycle so data sampled at the rise stays aligned with it
    wire tck_rise = tck_sync_ff[2] & tck_sync_ff[1] & ~tck_lvl_ff;
    wire tck_fall = ~tck_sync_ff[2] & ~tck_sync_ff[1] & tck_lvl_ff;
    wire tms_s = tms_lvl_ff;
    wire tdi_s = tdi_lvl_ff;

    // ==================================================
    // Controller state machine
    // Five high mode bits reach reset from any state; a cut frame leaves
    // the state where it stopped, as only a seen rise moves it
    reg [3:0] state_ff;
    reg [3:0] nxt_state;
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RESET: nxt_state = tms_s ? ST_RESET : ST_IDLE;
            ST_IDLE: nxt_state = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: nxt_state = tms_s ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: nxt_state = tms_s ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: nxt_state = tms_s ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: nxt_state = tms_s ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: nxt_state = tms_s ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: nxt_state = tms_s ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: nxt_state = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: nxt_state = tms_s ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: nxt_state = tms_s ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: nxt_state = tms_s ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: nxt_state = tms_s ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: nxt_state = tms_s ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: nxt_state = tms_s ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: nxt_state = tms_s ? ST_SEL_DR : ST_IDLE;
            default: nxt_state = ST_RESET;
        endcase
    end

    // Global controls for every register; no configuration input exists,
    // so the port works in any configuration state
    wire shift_dr = (state_ff == ST_SH_DR);
    wire capture_dr = (state_ff == ST_CAP_DR);
    wire update_dr = (state_ff == ST_UPD_DR);
    wire shift_ir = (state_ff == ST_SH_IR);

    // ==================================================
    // Registers on the test clock rising edge
    reg [`IR_WIDTH-1:0] ir_shift_ff;
    reg [`IR_WIDTH-1:0] ir_ff;
    reg bypass_ff;
    reg [31:0] id_ff;
    reg [CHAIN_LEN-1:0] bsr_ff;
    reg [CHAIN_LEN-1:0] upd_ff;

    // Decode of the active instruction
    wire sel_bsr = (ir_ff == `IR_EXTEST) || (ir_ff == `IR_SAMPLE);
    wire sel_id = (ir_ff == `IR_IDCODE);
    wire test_mode = (ir_ff == `IR_EXTEST) || (ir_ff == `IR_CLAMP);
    wire highz_mode = (ir_ff == `IR_HIGHZ);
    // Clamp drives the update stage with bypass selected; high-z shuts
    // every pad driver but leaves the core inputs functional

    // Flat chain position of one stage of one cell
    function integer cell_idx;
        input integer pin;
        input integer pos;
        begin
            cell_idx = pin * `CELL_BITS + pos;
        end
    endfunction

    // Three-bit cell per I/O: bit 0 nearest serial out; pad, enable and
    // core values are all sampled so capture works in normal operation
    reg [CHAIN_LEN-1:0] cap_vec;
    integer i;
    always @* begin
        cap_vec = {CHAIN_LEN{1'b0}};
        for (i = 0; i < `IO_COUNT; i = i + 1) begin
            cap_vec[cell_idx(i, `CELL_OUT)] = core_output_value_in[i];
            cap_vec[cell_idx(i, `CELL_OE)] = core_output_enable_in[i];
            cap_vec[cell_idx(i, `CELL_IN)] = pad_in[i];
        end
    end

    always @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_RESET;
            ir_shift_ff <= {`IR_WIDTH{1'b0}};
            ir_ff <= `IR_IDCODE;
            bypass_ff <= 1'b0;
            id_ff <= 32'h0;
            bsr_ff <= {CHAIN_LEN{1'b0}};
            upd_ff <= {CHAIN_LEN{1'b0}};
        end else if (tck_rise) begin
            state_ff <= nxt_state;
            // Instruction path; capture pattern ends in 01 so a broken
            // chain shows up at the tester
            if (state_ff == ST_CAP_IR) begin
                ir_shift_ff <= {{(`IR_WIDTH-2){1'b0}}, 2'b01};
            end else if (shift_ir) begin
                ir_shift_ff <= {tdi_s, ir_shift_ff[`IR_WIDTH-1:1]};
            end
            // Instruction falls back to the ID code as the controller enters
            // reset, so pads return to function without a further rise
            if (nxt_state == ST_RESET) begin
                ir_ff <= `IR_IDCODE;
            end else if (state_ff == ST_UPD_IR) begin
                ir_ff <= ir_shift_ff;
            end
            // Bypass: all unknown codes fall back to it
            // Captures zero, so a scan shows where each device sits
            if (capture_dr) begin
                bypass_ff <= 1'b0;
            end else if (shift_dr) begin
                bypass_ff <= tdi_s;
            end
            if (capture_dr && sel_id) begin
                id_ff <= `ID_VALUE;
            end else if (shift_dr && sel_id) begin
                id_ff <= {tdi_s, id_ff[31:1]};
            end
            // Boundary chain capture, shift, update
            if (capture_dr && sel_bsr) begin
                bsr_ff <= cap_vec;
            end else if (shift_dr && sel_bsr) begin
                bsr_ff <= {tdi_s, bsr_ff[CHAIN_LEN-1:1]};
            end
            if (update_dr && sel_bsr) begin
                upd_ff <= bsr_ff;
            end
        end
    end

    // ==================================================
    // Serial output: chosen register bit, launched on the falling edge
    // Launching on the fall gives the next device half a period of hold
    reg nxt_tdo;
    always @* begin
        if (shift_ir) begin
            nxt_tdo = ir_shift_ff[0];
        end else if (sel_bsr) begin
            nxt_tdo = bsr_ff[0];
        end else if (sel_id) begin
            nxt_tdo = id_ff[0];
        end else begin
            nxt_tdo = bypass_ff;
        end
    end

    always @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            tdo_out <= 1'b0;
            tdo_oe_out <= 1'b0;
        end else if (tck_fall) begin
            tdo_out <= nxt_tdo;
            tdo_oe_out <= shift_dr | shift_ir;
        end
    end

    // ==================================================
    // Pad and core drive: mode select picks update stage or function
    // Registered every cycle, so a mode change reaches the pads one clock
    // later and never glitches them
    integer k;
    always @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pad_out <= {`IO_COUNT{1'b0}};
            pad_oe_out <= {`IO_COUNT{1'b0}};
            core_input_drive_out <= {`IO_COUNT{1'b0}};
        end else begin
            for (k = 0; k < `IO_COUNT; k = k + 1) begin
                if (test_mode) begin
                    pad_out[k] <= upd_ff[cell_idx(k, `CELL_OUT)];
                    pad_oe_out[k] <= upd_ff[cell_idx(k, `CELL_OE)];
                    core_input_drive_out[k] <= upd_ff[cell_idx(k, `CELL_IN)];
                end else begin
                    pad_out[k] <= core_output_value_in[k];
                    pad_oe_out[k] <= core_output_enable_in[k] & ~highz_mode;
                    core_input_drive_out[k] <= pad_in[k];
                end
            end
        end
    end

endmodule // jtag_boundary_scan_tap

`default_nettype wire

// [bench/tap_tester.sv]
`default_nettype none
// ==========================================
// Tester model on the far side of the test port
module tap_tester (
    input wire logic clk_in,
    input wire logic tdo_in,
    input wire logic tdo_oe_in,
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] data = '0;
    event got;
    // Clock parked low between frames, data lines at pull-up level
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b1;
    end
    // One 160 ns test clock period; lines change only with the fall
    task automatic step(input logic m, input logic d, output logic o);
        tms_out <= m;
        tdi_out <= d;
        repeat (8) @(posedge clk_in);
        tck_out <= 1'b1;
        o = tdo_oe_in ? tdo_in : ~tdo_in;
        repeat (8) @(posedge clk_in);
        tck_out <= 1'b0;
    endtask
    // No reset pin, so five high mode bits then park in idle
    task automatic reset_walk();
        logic o;
        repeat (5) step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask
    // Scan from idle back to idle, lsb first, result kept in data
    task automatic scan(input logic ir, input int n, input logic [31:0] din);
        logic o;
        step(1'b1, 1'b1, o);
        if (ir)
            step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            data[i] = o;
        end
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        -> got;
    endtask
endmodule // tap_tester
`default_nettype wire

// [bench/tap_checker_asserts.sv]
`include "tap_defs.vh"
`default_nettype none
// ==========================================
// Port checker
module tap_checker (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    input wire logic tdo_out,
    input wire logic tdo_oe_out,
    input wire logic [`IO_COUNT-1:0] core_output_value_in,
    input wire logic [`IO_COUNT-1:0] core_output_enable_in,
    input wire logic [`IO_COUNT-1:0] pad_in,
    input wire logic [`IO_COUNT-1:0] pad_out,
    input wire logic [`IO_COUNT-1:0] pad_oe_out,
    input wire logic [`IO_COUNT-1:0] core_input_drive_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic tck_d_ff;
    logic [2:0] ones_ff;
    default clocking @(posedge ref_clk_in);
    endclocking
    default disable iff (!rstn_in);
    // Run of test clock rises with mode select high, saturating
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tck_d_ff <= 1'b0;
            ones_ff <= 3'h0;
        end else begin
            tck_d_ff <= tck_in;
            if (tck_in && !tck_d_ff)
                ones_ff <= tms_in ? ones_ff + {2'h0, ones_ff != 3'h7} : 3'h0;
        end
    end
    sequence tlr_fall;
        $fell(tck_in) && ones_ff >= 3'h5;
    endsequence
    chk_reset_quiet: assert property ($rose(rstn_in) |-> !tdo_oe_out)
        else $error("tdo driven at reset");
    chk_tdo_edge: assert property ($changed(tdo_out) |-> !tck_in)
        else $error("tdo moved with clock high");
    chk_oe_edge: assert property ($changed(tdo_oe_out) |-> !tck_in)
        else $error("tdo enable moved with clock high");
    chk_tdo_hold: assert property ($rose(tck_in) |=> $stable(tdo_out) [*4])
        else $error("tdo unstable after rise");
    chk_oe_hold: assert property ($rose(tck_in) |=> $stable(tdo_oe_out) [*4])
        else $error("tdo enable unstable after rise");
    chk_tlr_pads: assert property (tlr_fall |-> ##3 (pad_out == $past(core_output_value_in)
        && pad_oe_out == $past(core_output_enable_in))) else $error("pads not functional");
    chk_tlr_core: assert property (tlr_fall |-> ##3 core_input_drive_out == $past(pad_in))
        else $error("core input not functional");
    chk_tlr_quiet: assert property (tlr_fall |-> ##6 !tdo_oe_out)
        else $error("tdo driven in reset state");
endmodule // tap_checker
`default_nettype wire

// [bench/tb_jtag_boundary_scan_tap.sv]
`include "tap_defs.vh"
`default_nettype none
// ==========================================
// Bench top
module tb_jtag_boundary_scan_tap;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic tck, tms, tdi, tdo, tdo_oe;
    logic [3:0] cov, coe, pin, pout, poe, cin;
    logic [31:0] p;
    logic [63:0] e;
    logic [63:0] exp_q[$];
    logic [9:0] codes[5] = '{`IR_BYPASS, `IR_USERCODE, 10'h155, `IR_CLAMP, `IR_HIGHZ};
    int errors = 0;
    int samples_checked = 0;
    int seed = 86;
    always #5 clk = ~clk;
    jtag_boundary_scan_tap dut (.ref_clk_in(clk), .rstn_in(rstn), .tck_in(tck), .tms_in(tms),
        .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe), .core_output_value_in(cov),
        .core_output_enable_in(coe), .pad_in(pin), .pad_out(pout), .pad_oe_out(poe),
        .core_input_drive_out(cin));
    tap_tester tst (.clk_in(clk), .tdo_in(tdo), .tdo_oe_in(tdo_oe), .tck_out(tck),
        .tms_out(tms), .tdi_out(tdi));
    // Pin values in scan order: pad in, enable, value per cell
    function automatic logic [11:0] pack(input logic [3:0] o, en, i);
        for (int k = 0; k < 4; k++)
            pack[3*k +: 3] = {o[k], en[k], i[k]};
    endfunction
    task automatic cmp(input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_pad(input logic [11:0] got, exp);
        cmp({20'h0, got}, {20'h0, exp});
    endtask
    task automatic run(input logic ir, input int n, input logic [31:0] din, mask, expv);
        exp_q.push_back({mask, expv});
        tst.scan(ir, n, din);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Each finished scan is matched against the oldest note
    always @(tst.got) begin
        e = exp_q.pop_front();
        cmp(tst.data & e[63:32], e[31:0]);
    end
    // Hang guard
    initial begin
        #300000;
        errors++;
        summarize();
    end
    // Main sequence
    initial begin
        {cov, coe, pin} <= 12'h0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        tst.reset_walk();
        run(1'b0, 32, $random(seed), 32'hFFFF_FFFF, `ID_VALUE);
        $display("id done");
        coe <= 4'hF;
        foreach (codes[k]) begin
            p = $random(seed);
            run(1'b1, 10, {22'h0, codes[k]}, 32'h3, 32'h1);
            run(1'b0, 8, p, 32'hFF, {p[6:0], 1'b0});
        end
        cmp_pad({8'h0, poe}, 12'h0);
        $display("bypass done");
        p = $random(seed);
        {cov, coe, pin} <= p[11:0];
        run(1'b1, 10, `IR_SAMPLE, 32'h3, 32'h1);
        cmp_pad(pack(pout, poe, cin), pack(cov, coe, pin));
        p = $random(seed);
        run(1'b0, 12, p, 32'hFFF, pack(cov, coe, pin));
        run(1'b1, 10, `IR_EXTEST, 32'h3, 32'h1);
        cmp_pad(pack(pout, poe, cin), p[11:0]);
        run(1'b0, 12, ~p, 32'hFFF, pack(cov, coe, pin));
        cmp_pad(pack(pout, poe, cin), ~p[11:0]);
        run(1'b1, 10, `IR_CLAMP, 32'h3, 32'h1);
        cmp_pad(pack(pout, poe, cin), ~p[11:0]);
        $display("extest done");
        tst.reset_walk();
        cmp_pad(pack(pout, poe, cin), pack(cov, coe, pin));
        run(1'b0, 32, 32'h0, 32'hFFFF_FFFF, `ID_VALUE);
        $display("reset done");
        summarize();
    end
endmodule // tb_jtag_boundary_scan_tap
bind jtag_boundary_scan_tap tap_checker chk (.*);
`default_nettype wire
